// ### logic/hsc_status.sv
// hsc_status: hypervisor status word of one hart, with the virtualization
// mode, trap-entry capture and the guest instruction checks.
// assumes csr writes, trap entry and sret arrive as one-cycle pulses from
// the pipeline on clk_sys, and that the pipeline reads the verdicts
// combinationally in the cycle it presents the instruction.
//
// Overview of operation
// - word is host width wide; guest width at 33:32 only in 64-bit layout.
// - host width 32 drops the guest width field; guest width is 32.
// - 64-bit host: guest width takes any write, keeps legal values only.
// - host width growing from 32 loads the widest supported guest width.
// - return-trap bit 22 makes guest supervisor sret a virtual trap.
// - wait-trap bit 21, machine wait-trap clear: stalled guest wfi traps.
// - optionally every guest wfi traps under the wait-trap condition.
// - translation-trap bit 20 traps guest fences and translation root access.
// - guest trap bits act only in guest supervisor mode, virtually.
// - guest interrupt select 17:12 holds zero up to count; zero is none.
// - with no guest interrupt sources the select reads zero.
// - user-hypervisor bit 9 lets user mode run guest loads and stores.
// - every trap into host supervisor writes bit 7 with prior mode.
// - sret with mode 0 restores the mode from bit 7.
// - trap from a guest writes bit 8 with nominal privilege.
// - guest loads and stores take their privilege from bit 8.
// - host supervisor and user moves leave bit 8 alone.
// - trap writes bit 6 with whether a guest virtual address was saved.
// - big-endian bit 5 sets guest supervisor load and store byte order.
// - the same bit sets byte order of guest page table walks.
// - the big-endian bit may be fixed to the host byte order.
// - mode 1 is a guest with two-stage translation; 0 is host.
`timescale 1ns/1ns
`default_nettype none
module hsc_status #(
  parameter int GUEST_IRQ_COUNT = hsc_pkg::GUEST_IRQ_COUNT_DEF,
  parameter bit GWIDTH_FIXED = 1'b0,
  parameter bit GUEST32_OK = 1'b1,
  parameter bit GBE_WRITABLE = 1'b1,
  parameter bit HOST_BIG_ENDIAN = 1'b0,
  parameter bit WFI_ALWAYS_TRAP = 1'b0,
  parameter int WFI_LIMIT = hsc_pkg::WFI_LIMIT_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic host_width_64,
  input wire logic csr_we,
  input wire logic [63:0] csr_wdata,
  output logic [63:0] csr_rdata,
  input wire logic trap_take,
  input wire logic trap_guest_va,
  input wire logic sret_exec,
  input wire logic v_load,
  input wire logic v_load_val,
  input wire logic [1:0] cur_priv,
  input wire hsc_pkg::hsc_instr_t instr_class,
  input wire logic wfi_stalled,
  input wire logic mach_wait_trap,
  output logic virt_mode,
  output logic virt_instr_exc,
  output logic illegal_instr_exc,
  output logic [1:0] hyp_access_priv,
  output logic guest_big_endian,
  output logic [1:0] guest_width,
  output logic [5:0] guest_irq_select
);

  localparam int CNT_W = $clog2(WFI_LIMIT + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WFI_LIMIT - 1);
  localparam logic [5:0] IRQ_MAX = 6'(GUEST_IRQ_COUNT);

  logic [1:0] gwidth_reg, gwidth_next;
  logic ret_trap_reg, ret_trap_next;
  logic wait_trap_reg, wait_trap_next;
  logic xlat_trap_reg, xlat_trap_next;
  logic [5:0] irq_sel_reg, irq_sel_next;
  logic user_hyp_reg, user_hyp_next;
  logic prev_priv_reg, prev_priv_next;
  logic prev_mode_reg, prev_mode_next;
  logic guest_va_reg, guest_va_next;
  logic gbe_reg, gbe_next;
  logic v_reg, v_next;
  logic hw64_reg, hw64_next;
  hsc_pkg::hsc_wfi_state_t wfi_reg, wfi_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [5:0] wr_irq_sel;
  logic [1:0] wr_gwidth;
  logic guest_s;
  logic wfi_cond;

  assign guest_s = hsc_pkg::is_guest_s(v_reg, cur_priv);
  assign wr_irq_sel = csr_wdata[hsc_pkg::POS_IRQ_SEL_LO +: hsc_pkg::IRQ_W];
  assign wr_gwidth = csr_wdata[hsc_pkg::POS_GWIDTH_LO +: 2];

  // status word fields
  always_comb begin
    gwidth_next = gwidth_reg;
    ret_trap_next = ret_trap_reg;
    wait_trap_next = wait_trap_reg;
    xlat_trap_next = xlat_trap_reg;
    irq_sel_next = irq_sel_reg;
    user_hyp_next = user_hyp_reg;
    prev_priv_next = prev_priv_reg;
    prev_mode_next = prev_mode_reg;
    guest_va_next = guest_va_reg;
    gbe_next = gbe_reg;
    hw64_next = host_width_64;
    if (csr_we) begin
      ret_trap_next = csr_wdata[hsc_pkg::POS_RET_TRAP];
      wait_trap_next = csr_wdata[hsc_pkg::POS_WAIT_TRAP];
      xlat_trap_next = csr_wdata[hsc_pkg::POS_XLAT_TRAP];
      user_hyp_next = csr_wdata[hsc_pkg::POS_USER_HYP];
      prev_priv_next = csr_wdata[hsc_pkg::POS_PREV_PRIV];
      prev_mode_next = csr_wdata[hsc_pkg::POS_PREV_MODE];
      guest_va_next = csr_wdata[hsc_pkg::POS_GUEST_VA];
      // out-of-range selects are dropped so the field never leaves range
      if (GUEST_IRQ_COUNT != 0 && wr_irq_sel <= IRQ_MAX) begin
        irq_sel_next = wr_irq_sel;
      end
      if (GBE_WRITABLE) begin
        gbe_next = csr_wdata[hsc_pkg::POS_GUEST_BE];
      end
      // field only exists with a 64-bit host; illegal codes are ignored
      if (host_width_64 && !GWIDTH_FIXED) begin
        if (wr_gwidth == hsc_pkg::WIDTH_64 ||
            (GUEST32_OK && wr_gwidth == hsc_pkg::WIDTH_32)) begin
          gwidth_next = wr_gwidth;
        end
      end
    end
    // width growing from 32: widest guest width that fits is 64
    if (host_width_64 && !hw64_reg && !GWIDTH_FIXED) begin
      gwidth_next = hsc_pkg::WIDTH_64;
    end
    // hardware capture wins over a csr write in the same cycle
    if (trap_take) begin
      prev_mode_next = v_reg;
      if (v_reg) begin // host-side traps leave it alone
        prev_priv_next = (cur_priv == hsc_pkg::PRIV_S);
      end
      guest_va_next = trap_guest_va;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gwidth_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_GWIDTH_LO +: 2];
      ret_trap_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_RET_TRAP];
      wait_trap_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_WAIT_TRAP];
      xlat_trap_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_XLAT_TRAP];
      irq_sel_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_IRQ_SEL_LO +: 6];
      user_hyp_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_USER_HYP];
      prev_priv_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_PREV_PRIV];
      prev_mode_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_PREV_MODE];
      guest_va_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_GUEST_VA];
      gbe_reg <= hsc_pkg::RESET_VAL[hsc_pkg::POS_GUEST_BE];
      hw64_reg <= 1'b1;
    end else begin
      gwidth_reg <= gwidth_next;
      ret_trap_reg <= ret_trap_next;
      wait_trap_reg <= wait_trap_next;
      xlat_trap_reg <= xlat_trap_next;
      irq_sel_reg <= irq_sel_next;
      user_hyp_reg <= user_hyp_next;
      prev_priv_reg <= prev_priv_next;
      prev_mode_reg <= prev_mode_next;
      guest_va_reg <= guest_va_next;
      gbe_reg <= gbe_next;
      hw64_reg <= hw64_next;
    end
  end

  // virtualization mode
  always_comb begin
    v_next = v_reg;
    if (trap_take) begin
      v_next = 1'b0;
    end else if (v_load) begin
      v_next = v_load_val;
    end else if (sret_exec && !v_reg) begin
      v_next = prev_mode_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      v_reg <= 1'b0;
    end else begin
      v_reg <= v_next;
    end
  end

  // bounded wfi wait; a wfi that completes early leaves the count idle
  assign wfi_cond = (instr_class == hsc_pkg::HSC_I_WFI) && guest_s &&
                    wait_trap_reg && !mach_wait_trap && wfi_stalled;

  always_comb begin
    wfi_next = wfi_reg;
    cnt_next = cnt_reg;
    case (wfi_reg)
      hsc_pkg::HSC_W_IDLE: begin
        cnt_next = '0;
        if (wfi_cond) begin
          wfi_next = hsc_pkg::HSC_W_COUNT;
        end
      end
      hsc_pkg::HSC_W_COUNT: begin
        if (!wfi_cond) begin
          wfi_next = hsc_pkg::HSC_W_IDLE;
        end else if (cnt_reg == CNT_LAST) begin
          wfi_next = hsc_pkg::HSC_W_EXPIRED;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      hsc_pkg::HSC_W_EXPIRED: begin
        if (!wfi_cond) begin
          wfi_next = hsc_pkg::HSC_W_IDLE;
        end
      end
      default: begin
        wfi_next = hsc_pkg::HSC_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wfi_reg <= hsc_pkg::HSC_W_IDLE;
      cnt_reg <= '0;
    end else begin
      wfi_reg <= wfi_next;
      cnt_reg <= cnt_next;
    end
  end

  hsc_chk_if chk_bus ();

  assign chk_bus.instr = instr_class;
  assign chk_bus.in_guest_s = guest_s;
  assign chk_bus.in_host_u = hsc_pkg::is_host_u(v_reg, cur_priv);
  assign chk_bus.ret_trap = ret_trap_reg;
  assign chk_bus.xlat_trap = xlat_trap_reg;
  assign chk_bus.user_hyp = user_hyp_reg;
  // the always-trap option trades guest wfi latency for a simpler core
  assign chk_bus.wfi_expired = wait_trap_reg && !mach_wait_trap &&
    (WFI_ALWAYS_TRAP || wfi_reg == hsc_pkg::HSC_W_EXPIRED);

  hsc_trap_check u_check (
    .bus(chk_bus.chk)
  );

  assign virt_instr_exc = chk_bus.virt_exc;
  assign illegal_instr_exc = chk_bus.illegal_exc;

  // outputs steering the pipeline
  assign virt_mode = v_reg;
  assign hyp_access_priv =
    prev_priv_reg ? hsc_pkg::PRIV_S : hsc_pkg::PRIV_U;
  assign guest_big_endian =
    GBE_WRITABLE ? gbe_reg : HOST_BIG_ENDIAN;
  assign guest_width =
    host_width_64 ? gwidth_reg : hsc_pkg::WIDTH_32;
  assign guest_irq_select =
    (GUEST_IRQ_COUNT == 0) ? 6'h00 : irq_sel_reg;

  // read view; reserved positions read zero
  always_comb begin
    csr_rdata = '0;
    if (host_width_64) begin
      csr_rdata[hsc_pkg::POS_GWIDTH_LO +: 2] = gwidth_reg;
    end
    csr_rdata[hsc_pkg::POS_RET_TRAP] = ret_trap_reg;
    csr_rdata[hsc_pkg::POS_WAIT_TRAP] = wait_trap_reg;
    csr_rdata[hsc_pkg::POS_XLAT_TRAP] = xlat_trap_reg;
    csr_rdata[hsc_pkg::POS_IRQ_SEL_LO +: hsc_pkg::IRQ_W] = guest_irq_select;
    csr_rdata[hsc_pkg::POS_USER_HYP] = user_hyp_reg;
    csr_rdata[hsc_pkg::POS_PREV_PRIV] = prev_priv_reg;
    csr_rdata[hsc_pkg::POS_PREV_MODE] = prev_mode_reg;
    csr_rdata[hsc_pkg::POS_GUEST_VA] = guest_va_reg;
    csr_rdata[hsc_pkg::POS_GUEST_BE] = guest_big_endian;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  prev_mode_a: assert property (
    trap_take |=> prev_mode_reg == $past(v_reg))
    else $error("prior mode not captured on trap");
  sret_mode_a: assert property (
    sret_exec && !v_reg && !trap_take && !v_load
    |=> v_reg == $past(prev_mode_reg))
    else $error("sret did not restore mode");
  prev_priv_a: assert property (
    trap_take && v_reg
    |=> prev_priv_reg == ($past(cur_priv) == hsc_pkg::PRIV_S))
    else $error("guest privilege not captured");
  priv_hold_a: assert property (
    !csr_we && !(trap_take && v_reg) |=> $stable(prev_priv_reg))
    else $error("guest privilege changed without cause");
  guest_va_a: assert property (
    trap_take |=> guest_va_reg == $past(trap_guest_va))
    else $error("guest address flag wrong after trap");
  width32_a: assert property (
    !host_width_64 |->
    guest_width == hsc_pkg::WIDTH_32 && csr_rdata[63:32] == 32'h0000_0000)
    else $error("32-bit host shows a guest width field");
  width_grow_a: assert property (
    host_width_64 && !hw64_reg && !GWIDTH_FIXED
    |=> gwidth_reg == hsc_pkg::WIDTH_64)
    else $error("guest width not widened");
  irq_range_a: assert property (guest_irq_select <= IRQ_MAX)
    else $error("interrupt select out of range");
  ret_trap_a: assert property (
    instr_class == hsc_pkg::HSC_I_SRET && guest_s && ret_trap_reg
    |-> virt_instr_exc && !illegal_instr_exc)
    else $error("guest sret not trapped");
  vm_trap_a: assert property (
    instr_class == hsc_pkg::HSC_I_SATP && guest_s
    |-> virt_instr_exc == xlat_trap_reg)
    else $error("translation root access trap wrong");
  host_quiet_a: assert property (!guest_s |-> !virt_instr_exc)
    else $error("virtual trap outside guest supervisor");
  hyp_user_a: assert property (
    hsc_pkg::is_host_u(v_reg, cur_priv) &&
    instr_class == hsc_pkg::HSC_I_HLSV |-> illegal_instr_exc == !user_hyp_reg)
    else $error("user guest access check wrong");
  wfi_bound_a: assert property (
    wfi_reg == hsc_pkg::HSC_W_COUNT && wfi_cond && cnt_reg == CNT_LAST
    |=> wfi_reg == hsc_pkg::HSC_W_EXPIRED)
    else $error("wfi wait overran its limit");
  wfi_trap_a: assert property (
    wfi_cond && wfi_reg == hsc_pkg::HSC_W_EXPIRED |-> virt_instr_exc)
    else $error("expired guest wfi not trapped");

endmodule : hsc_status
`default_nettype wire

// ### logic/hsc_pkg.sv
// hsc_pkg: field layout, encodings, reset value and timing of the
// hypervisor status word.
// assumes a 125 MHz hart clock shared by the csr port and the pipeline.
package hsc_pkg;

  localparam int XLEN = 64;
  localparam int HALF = 32;

  // field positions
  localparam int POS_GWIDTH_LO = 32;
  localparam int POS_RET_TRAP = 22;
  localparam int POS_WAIT_TRAP = 21;
  localparam int POS_XLAT_TRAP = 20;
  localparam int POS_IRQ_SEL_LO = 12;
  localparam int IRQ_W = 6;
  localparam int POS_USER_HYP = 9;
  localparam int POS_PREV_PRIV = 8;
  localparam int POS_PREV_MODE = 7;
  localparam int POS_GUEST_VA = 6;
  localparam int POS_GUEST_BE = 5;

  // base-width encodings
  localparam logic [1:0] WIDTH_32 = 2'h1;
  localparam logic [1:0] WIDTH_64 = 2'h2;

  // nominal privilege codes
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;

  // guest width at 64 bits, all other fields clear
  localparam logic [63:0] RESET_VAL = 64'h0000_0002_0000_0000;

  localparam int GUEST_IRQ_COUNT_DEF = 6;

  // bounded wfi wait before a guest wfi is trapped
  localparam int CLK_PERIOD_NS = 8;
  localparam int WFI_LIMIT_NS = 1000;
  localparam int WFI_LIMIT_CYC = WFI_LIMIT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    HSC_I_NONE = 3'b000,
    HSC_I_SRET = 3'b001,
    HSC_I_WFI = 3'b010,
    HSC_I_SFENCE = 3'b011,
    HSC_I_SINVAL = 3'b100,
    HSC_I_SATP = 3'b101,
    HSC_I_HLSV = 3'b110,
    HSC_I_HOTHER = 3'b111
  } hsc_instr_t;

  typedef enum logic [1:0] {
    HSC_W_IDLE = 2'b00,
    HSC_W_COUNT = 2'b01,
    HSC_W_EXPIRED = 2'b10
  } hsc_wfi_state_t;

  function automatic logic is_guest_s(logic v, logic [1:0] priv);
    return v && (priv == PRIV_S);
  endfunction : is_guest_s

  function automatic logic is_host_u(logic v, logic [1:0] priv);
    return !v && (priv == PRIV_U);
  endfunction : is_host_u

endpackage : hsc_pkg

// ### logic/hsc_chk_if.sv
// hsc_chk_if: carries the guest trap controls and the current mode into
// the instruction check, and its two exception verdicts back.
// assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface hsc_chk_if;
  hsc_pkg::hsc_instr_t instr;
  logic in_guest_s;
  logic in_host_u;
  logic ret_trap;
  logic xlat_trap;
  logic user_hyp;
  logic wfi_expired;
  logic virt_exc;
  logic illegal_exc;

  modport chk (
    input instr, in_guest_s, in_host_u, ret_trap, xlat_trap, user_hyp,
    input wfi_expired,
    output virt_exc, illegal_exc
  );
  modport ctl (
    output instr, in_guest_s, in_host_u, ret_trap, xlat_trap, user_hyp,
    output wfi_expired,
    input virt_exc, illegal_exc
  );
endinterface : hsc_chk_if
`default_nettype wire

// ### logic/hsc_trap_check.sv
// hsc_trap_check: decides, per issued instruction, whether the status
// word turns it into a virtual-instruction or illegal-instruction trap.
// assumes the caller has already worked out the mode and the wfi timer.
`timescale 1ns/1ns
`default_nettype none
module hsc_trap_check (
  hsc_chk_if.chk bus
);

  always_comb begin
    bus.virt_exc = 1'b0;
    bus.illegal_exc = 1'b0;
    if (bus.in_guest_s) begin
      // traps here are virtual, never illegal
      case (bus.instr)
        hsc_pkg::HSC_I_SRET: bus.virt_exc = bus.ret_trap;
        hsc_pkg::HSC_I_WFI: bus.virt_exc = bus.wfi_expired;
        hsc_pkg::HSC_I_SFENCE,
        hsc_pkg::HSC_I_SINVAL,
        hsc_pkg::HSC_I_SATP: bus.virt_exc = bus.xlat_trap;
        default: bus.virt_exc = 1'b0;
      endcase
    end else if (bus.in_host_u) begin
      case (bus.instr)
        hsc_pkg::HSC_I_HLSV: bus.illegal_exc = !bus.user_hyp;
        hsc_pkg::HSC_I_HOTHER: bus.illegal_exc = 1'b1;
        default: bus.illegal_exc = 1'b0;
      endcase
    end
  end

endmodule : hsc_trap_check
`default_nettype wire

// ### test/hsc_hart_model.sv
// hsc_hart_model: stands in for the hart pipeline that feeds the status word
// with trap entry, sret, mode loads and the presented instruction.
// assumes the bench calls its tasks; every change lands at a falling edge.
`timescale 1ns/1ns
`default_nettype none
module hsc_hart_model (
  input wire logic clk_sys,
  output logic trap_take,
  output logic trap_guest_va,
  output logic sret_exec,
  output logic v_load,
  output logic v_load_val,
  output logic [1:0] cur_priv,
  output hsc_pkg::hsc_instr_t instr_class,
  output logic wfi_stalled,
  output logic mach_wait_trap
);
  initial begin
    trap_take = 1'b0;
    trap_guest_va = 1'b0;
    sret_exec = 1'b0;
    v_load = 1'b0;
    v_load_val = 1'b0;
    cur_priv = hsc_pkg::PRIV_M;
    instr_class = hsc_pkg::HSC_I_NONE;
    wfi_stalled = 1'b0;
    mach_wait_trap = 1'b0;
  end

  // one-cycle event: 0 trap, 1 sret, 2 mode load; val qualifies it
  task automatic pulse(input int sel, input logic val);
    @(negedge clk_sys);
    trap_take <= (sel == 0);
    sret_exec <= (sel == 1);
    v_load <= (sel == 2);
    trap_guest_va <= val;
    v_load_val <= val;
    @(negedge clk_sys);
    trap_take <= 1'b0;
    sret_exec <= 1'b0;
    v_load <= 1'b0;
    // qualifiers go stale, so they must not be trusted outside the pulse
    trap_guest_va <= ~val;
    v_load_val <= ~val;
  endtask : pulse

  task automatic present(input logic [1:0] p, input hsc_pkg::hsc_instr_t i,
                         input logic st, input logic mwt);
    @(negedge clk_sys);
    cur_priv <= p;
    instr_class <= i;
    wfi_stalled <= st;
    mach_wait_trap <= mwt;
    #1;
  endtask : present
endmodule : hsc_hart_model
`default_nettype wire

// ### test/testbench.sv
// testbench: self-checking bench for the hypervisor status word.
// assumes hsc_status and hsc_hart_model; wfi limit shortened to 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int WL = 4;
  localparam logic [63:0] RV = hsc_pkg::RESET_VAL;
  logic clk_sys, sys_rst, host_width_64, csr_we, trap_take, trap_guest_va;
  logic sret_exec, v_load, v_load_val, wfi_stalled, mach_wait_trap;
  logic virt_mode, virt_instr_exc, illegal_instr_exc, guest_big_endian;
  logic [63:0] csr_wdata, csr_rdata;
  logic [1:0] cur_priv, hyp_access_priv, guest_width;
  logic [5:0] guest_irq_select;
  hsc_pkg::hsc_instr_t instr_class;
  int bad_count, num_checks;

  hsc_status #(.WFI_LIMIT(WL)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .host_width_64(host_width_64), .csr_we(csr_we), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .trap_take(trap_take),
    .trap_guest_va(trap_guest_va), .sret_exec(sret_exec), .v_load(v_load),
    .v_load_val(v_load_val), .cur_priv(cur_priv), .instr_class(instr_class),
    .wfi_stalled(wfi_stalled), .mach_wait_trap(mach_wait_trap),
    .virt_mode(virt_mode), .virt_instr_exc(virt_instr_exc),
    .illegal_instr_exc(illegal_instr_exc), .hyp_access_priv(hyp_access_priv),
    .guest_big_endian(guest_big_endian), .guest_width(guest_width),
    .guest_irq_select(guest_irq_select));

  hsc_hart_model hart (.clk_sys(clk_sys), .trap_take(trap_take),
    .trap_guest_va(trap_guest_va), .sret_exec(sret_exec), .v_load(v_load),
    .v_load_val(v_load_val), .cur_priv(cur_priv), .instr_class(instr_class),
    .wfi_stalled(wfi_stalled), .mach_wait_trap(mach_wait_trap));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [63:0] m(input int p);
    return 64'h0000_0000_0000_0001 << p;
  endfunction : m

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [63:0] d);
    @(negedge clk_sys);
    csr_we <= 1'b1;
    csr_wdata <= d;
    @(negedge clk_sys);
    csr_we <= 1'b0;
    csr_wdata <= ~d;
  endtask : wr

  task automatic t_fields;
    check(csr_rdata, RV);
    check(virt_mode, 1'b0);
    wr(64'hFFFF_FFFF_FFFF_FFFF);
    // width code 3 and select 63 are refused, reserved bits read zero
    check(csr_rdata, RV | m(22) | m(21) | m(20) | m(9) | m(8) | m(7) | m(6)
          | m(5));
    wr(64'h0000_0001_0000_6000);
    check(guest_width, hsc_pkg::WIDTH_32);
    check(guest_irq_select, 6'h06);
    wr(64'h0000_0002_0000_7000);
    check(csr_rdata, 64'h0000_0002_0000_6000);
    $display("test fields done");
  endtask : t_fields

  task automatic t_width;
    wr(64'h0000_0001_0000_0000);
    @(negedge clk_sys);
    host_width_64 <= 1'b0;
    @(negedge clk_sys);
    check(guest_width, hsc_pkg::WIDTH_32);
    check(csr_rdata[63:32], 32'h0000_0000);
    host_width_64 <= 1'b1;
    @(negedge clk_sys);
    check(guest_width, hsc_pkg::WIDTH_64);
    $display("test width done");
  endtask : t_width

  task automatic t_trap;
    wr(RV);
    hart.present(hsc_pkg::PRIV_S, hsc_pkg::HSC_I_NONE, 1'b0, 1'b0);
    hart.pulse(2, 1'b1);
    check(virt_mode, 1'b1);
    hart.pulse(0, 1'b1);
    check(csr_rdata, RV | m(8) | m(7) | m(6));
    check(virt_mode, 1'b0);
    check(hyp_access_priv, hsc_pkg::PRIV_S);
    hart.present(hsc_pkg::PRIV_U, hsc_pkg::HSC_I_NONE, 1'b0, 1'b0);
    hart.pulse(0, 1'b0);
    check(csr_rdata, RV | m(8));
    hart.pulse(1, 1'b0);
    check(virt_mode, 1'b0);
    wr(RV | m(7));
    hart.pulse(1, 1'b0);
    check(virt_mode, 1'b1);
    hart.pulse(0, 1'b0);
    check(csr_rdata, RV | m(7));
    check(hyp_access_priv, hsc_pkg::PRIV_U);
    $display("test trap done");
  endtask : t_trap

  task automatic t_checks;
    hsc_pkg::hsc_instr_t ic;
    logic e;
    hart.pulse(2, 1'b1);
    wr(RV | m(22) | m(20));
    for (int i = 0; i < 6; i++) begin
      ic = hsc_pkg::hsc_instr_t'(i);
      e = (ic == hsc_pkg::HSC_I_SRET) || (ic >= hsc_pkg::HSC_I_SFENCE);
      hart.present(hsc_pkg::PRIV_S, ic, 1'b0, 1'b0);
      check({virt_instr_exc, illegal_instr_exc}, {e, 1'b0});
    end
    hart.present(hsc_pkg::PRIV_U, hsc_pkg::HSC_I_SRET, 1'b0, 1'b0);
    check(virt_instr_exc, 1'b0);
    hart.pulse(2, 1'b0);
    hart.present(hsc_pkg::PRIV_S, hsc_pkg::HSC_I_SATP, 1'b0, 1'b0);
    check(virt_instr_exc, 1'b0);
    hart.present(hsc_pkg::PRIV_U, hsc_pkg::HSC_I_HLSV, 1'b0, 1'b0);
    check({virt_instr_exc, illegal_instr_exc}, 2'h1);
    wr(RV | m(9));
    check(illegal_instr_exc, 1'b0);
    hart.present(hsc_pkg::PRIV_U, hsc_pkg::HSC_I_HOTHER, 1'b0, 1'b0);
    check(illegal_instr_exc, 1'b1);
    $display("test checks done");
  endtask : t_checks

  task automatic t_wfi;
    int n;
    hart.pulse(2, 1'b1);
    wr(RV | m(21));
    hart.present(hsc_pkg::PRIV_S, hsc_pkg::HSC_I_WFI, 1'b1, 1'b0);
    check(virt_instr_exc, 1'b0);
    // bounded wait: the trap must appear close to the shortened limit
    for (n = 0; n < 20 && virt_instr_exc !== 1'b1; n++) @(negedge clk_sys);
    if (n == 20) begin
      bad_count++;
      complete_run();
    end
    check(n >= WL && n <= WL + 2, 1'b1);
    hart.present(hsc_pkg::PRIV_S, hsc_pkg::HSC_I_WFI, 1'b0, 1'b0);
    hart.present(hsc_pkg::PRIV_S, hsc_pkg::HSC_I_WFI, 1'b1, 1'b1);
    repeat (2 * WL + 2) @(negedge clk_sys);
    check(virt_instr_exc, 1'b0);
    hart.present(hsc_pkg::PRIV_S, hsc_pkg::HSC_I_NONE, 1'b0, 1'b0);
    wr(RV | m(5));
    check(guest_big_endian, 1'b1);
    wr(RV);
    check(guest_big_endian, 1'b0);
    $display("test wfi and endian done");
  endtask : t_wfi

  initial begin
    bad_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    host_width_64 = 1'b1;
    csr_we = 1'b0;
    csr_wdata = 64'h0000_0000_0000_0000;
    repeat (2) @(negedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    t_fields();
    t_width();
    t_trap();
    t_checks();
    t_wfi();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
